// file: inc/isfl_pkg.sv
// constants for the two-wire interface status-flag block
// assumes a byte-wide register port and a 25 MHz module clock
package isfl_pkg;

  // ****************************************
  // register map, byte-wide registers
  // ****************************************
  localparam logic [2:0] ADDR_CTRL = 3'h0;
  localparam logic [2:0] ADDR_STATUS_ONE = 3'h1;
  localparam logic [2:0] ADDR_STATUS_TWO = 3'h2;
  localparam logic [2:0] ADDR_DATA = 3'h3;
  localparam logic [2:0] ADDR_IRQ_STAT = 3'h4;
  localparam logic [2:0] ADDR_IRQ_MASK = 3'h5;

  // ****************************************
  // control register fields
  // ****************************************
  localparam int CTRL_PE = 5;
  localparam int CTRL_GC = 4;
  localparam int CTRL_START = 3;
  localparam int CTRL_ACK = 2;
  localparam int CTRL_STOP = 1;
  localparam int CTRL_ITE = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // ****************************************
  // status_one fields
  // ****************************************
  localparam int S1_EVF = 7;
  localparam int S1_TEN_BIT_HEADER_SENT = 6;
  localparam int S1_DIR = 5;
  localparam int S1_BUSY = 4;
  localparam int S1_BTF = 3;
  localparam int S1_ADDRESS_MATCHED = 2;
  localparam int S1_ROLE = 1;
  localparam int S1_SB = 0;

  // ****************************************
  // status_two fields (stop and error events only)
  // ****************************************
  localparam int S2_AF = 4;
  localparam int S2_STOP_DETECTED = 3;
  localparam int S2_ARBITRATION_LOST = 2;
  localparam int S2_BUS_ERROR_FLAG = 1;

  // ****************************************
  // interrupt status and mask layout
  // ****************************************
  localparam int IRQ_SB = 0;
  localparam int IRQ_ADDRESS_MATCHED = 1;
  localparam int IRQ_BTF = 2;
  localparam int IRQ_TEN_BIT_HEADER_SENT = 3;
  localparam int IRQ_AF = 4;
  localparam int IRQ_STOP_DETECTED = 5;
  localparam int IRQ_ARBITRATION_LOST = 6;
  localparam int IRQ_BUS_ERROR_FLAG = 7;
  localparam logic [7:0] IRQ_MASK_RESET = 8'h00;

endpackage : isfl_pkg

// file: hw/isfl_flags.sv
// status-flag logic of a multimaster two-wire serial interface
// assumes a shift engine on the same clock that pulses byte and address events,
// and raw bus pins from outside the clock domain
//
// What this block does
// - event summary set by any listed event
// - summary cleared by status reads or sequence
// - disable clears all status_one flags except busy
// - header flag: set on header, cleared two-step
// - direction shows last byte, clears with transfer
// - busy set on start, cleared stop/error
// - busy frozen while interface is disabled
// - transfer-finished set per byte, may interrupt
// - transmit: set after ack, cleared read-write
// - receive: set if ack on, cleared read-read
// - clock held low while transfer-finished set
// - address matched set, read of status clears
// - clock held low while address matched
// - role master on start write, slave on stop/loss
// - start flag set when sent, cleared read-write
// - clock held for header, start, address ack
// - disabled: controls reset except stop, pins released
`timescale 1ns/1ps

module isfl_flags (
  input wire logic i_mclk, // module clock, 25 MHz
  input wire logic i_rst, // asynchronous reset, active high
  input wire logic [2:0] i_addr, // register address
  input wire logic [7:0] i_wdata, // register write data
  input wire logic i_wr, // write strobe
  input wire logic i_rd, // read strobe
  output logic [7:0] o_rdata, // read data, cycle after read strobe
  input wire logic i_scl, // serial clock pin level
  input wire logic i_sda, // serial data pin level
  output logic o_scl_o, // serial clock drive value, always low
  output logic o_scl_oe, // serial clock drive enable, stretches bus
  input wire logic i_start_sent, // engine: start condition generated
  input wire logic i_header_sent, // engine: ten-bit header byte sent
  input wire logic i_addr_ack, // engine: address acknowledged event
  input wire logic i_byte_tx, // engine: data byte sent, ack clocked
  input wire logic i_byte_rx, // engine: data byte received, ack clocked
  input wire logic i_addr_match, // engine: slave address or general call
  input wire logic i_ack_fail, // engine: no acknowledge after byte
  input wire logic i_arb_lost, // engine: arbitration lost
  input wire logic i_bus_err, // engine: misplaced start or stop
  input wire logic [7:0] i_rx_byte, // engine: received byte
  output logic [7:0] o_tx_byte, // byte written by software
  output logic o_pe, // peripheral enable
  output logic o_start_req, // start request to engine
  output logic o_stop_req, // stop request to engine
  output logic o_ack_en, // acknowledge enable
  output logic o_gc_en, // general call enable
  output logic o_irq // level interrupt
);

  // ****************************************
  // state
  // ****************************************
  logic [7:0] ctrl;
  logic [7:0] irq_stat;
  logic [7:0] irq_mask;
  logic ten_bit_header_sent, dir, busy, transfer_finished, address_matched, role, sb, event_summary_flag;
  logic af, stop_detected, arbitration_lost, bus_error_flag;
  logic ev6_hold;
  logic s1_armed, s2_armed;
  logic scl_m, scl_s, sda_m, sda_s, sda_prev;

  logic pe;
  assign pe = ctrl[isfl_pkg::CTRL_PE];

  // ****************************************
  // register access decode
  // ****************************************
  // unmapped offsets decode to nothing: reads give zero, writes are lost
  wire wr_ctrl = i_wr && (i_addr == isfl_pkg::ADDR_CTRL);
  wire rd_s1 = i_rd && (i_addr == isfl_pkg::ADDR_STATUS_ONE);
  wire rd_s2 = i_rd && (i_addr == isfl_pkg::ADDR_STATUS_TWO);
  wire wr_dr = i_wr && (i_addr == isfl_pkg::ADDR_DATA);
  wire rd_dr = i_rd && (i_addr == isfl_pkg::ADDR_DATA);
  wire rd_irq = i_rd && (i_addr == isfl_pkg::ADDR_IRQ_STAT);
  wire wr_mask = i_wr && (i_addr == isfl_pkg::ADDR_IRQ_MASK);

  // ****************************************
  // pin synchronisers and bus condition detect
  // ****************************************
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_prev <= 1'b1;
    end
    else
    begin
      scl_m <= i_scl;
      scl_s <= scl_m;
      sda_m <= i_sda;
      sda_s <= sda_m;
      sda_prev <= sda_s;
    end
  end

  // a released line idles high, so the reset level gives no false edge
  // data falls or rises while clock stays high
  wire start_det = scl_s && sda_prev && !sda_s;
  wire stop_det = scl_s && !sda_prev && sda_s;

  // ****************************************
  // control register next value
  // ****************************************
  logic [7:0] next_ctrl;
  always_comb
  begin
    next_ctrl = ctrl;
    if (wr_ctrl && !pe)
    begin
      // first write only enables; stop survives
      next_ctrl = 8'h00;
      next_ctrl[isfl_pkg::CTRL_PE] = i_wdata[isfl_pkg::CTRL_PE];
      next_ctrl[isfl_pkg::CTRL_STOP] = i_wdata[isfl_pkg::CTRL_STOP];
    end
    else if (wr_ctrl)
    begin
      next_ctrl = {2'b00, i_wdata[5:0]};
    end
    // the request withdraws once the start is on the bus, unless rewritten
    if (pe && i_start_sent && !(wr_ctrl && i_wdata[isfl_pkg::CTRL_START]))
    begin
      next_ctrl[isfl_pkg::CTRL_START] = 1'b0;
    end
    if (!next_ctrl[isfl_pkg::CTRL_PE])
    begin
      next_ctrl[isfl_pkg::CTRL_GC] = 1'b0;
      next_ctrl[isfl_pkg::CTRL_START] = 1'b0;
      next_ctrl[isfl_pkg::CTRL_ACK] = 1'b0;
      next_ctrl[isfl_pkg::CTRL_ITE] = 1'b0;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
      ctrl <= isfl_pkg::CTRL_RESET;
    else
      ctrl <= next_ctrl;
  end

  // ****************************************
  // clear sequences: status read arms, data access fires
  // ****************************************
  wire seq1_wr = s1_armed && wr_dr;
  wire seq1_rd = s1_armed && rd_dr;
  wire seq2_wr = s2_armed && wr_dr;
  wire start_wr = pe && wr_ctrl && i_wdata[isfl_pkg::CTRL_START];

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      s1_armed <= 1'b0;
      s2_armed <= 1'b0;
    end
    else
    begin
      // any data access disarms, so an old read cannot clear a later byte
      s1_armed <= pe && (rd_s1 || (s1_armed && !wr_dr && !rd_dr));
      s2_armed <= pe && (rd_s2 || (s2_armed && !wr_dr && !rd_dr));
    end
  end

  // ****************************************
  // status_one flag next values
  // ****************************************
  logic next_sb, next_ten_bit_header_sent, next_btf, next_address_matched, next_dir, next_role, next_busy;
  logic next_af, next_stop_detected, next_arbitration_lost, next_bus_error_flag, next_ev6, next_evf;
  wire btf_set = i_byte_tx || (i_byte_rx && ctrl[isfl_pkg::CTRL_ACK]);
  wire btf_clr = dir ? seq1_wr : seq1_rd;

  always_comb
  begin
    // set terms come last so an event beats a same-cycle clear
    next_sb = sb && !seq1_wr;
    if (i_start_sent)
      next_sb = 1'b1;
    next_ten_bit_header_sent = ten_bit_header_sent && !seq2_wr;
    if (i_header_sent)
      next_ten_bit_header_sent = 1'b1;
    // a sent byte clears on the data write, a received one on the data read
    next_btf = transfer_finished && !btf_clr;
    if (btf_set)
      next_btf = 1'b1;
    next_address_matched = address_matched && !rd_s1;
    if (i_addr_match)
      next_address_matched = 1'b1;
    // direction is only kept while the byte flag stands
    next_dir = dir && next_btf && !stop_det && !i_arb_lost;
    if (btf_set)
      next_dir = i_byte_tx;
    next_role = role && !stop_det && !i_arb_lost;
    if (start_wr)
      next_role = 1'b1;
    // address acknowledge keeps the clock held until status_two is read
    next_ev6 = ev6_hold && !rd_s2;
    if (i_addr_ack)
      next_ev6 = 1'b1;
    // error causes clear on the status_two read itself
    next_af = (af && !rd_s2) || i_ack_fail;
    next_stop_detected = (stop_detected && !rd_s2) || stop_det;
    next_arbitration_lost = (arbitration_lost && !rd_s2) || i_arb_lost;
    next_bus_error_flag = (bus_error_flag && !rd_s2) || i_bus_err;
    if (!pe)
    begin
      next_sb = 1'b0;
      next_ten_bit_header_sent = 1'b0;
      next_btf = 1'b0;
      next_address_matched = 1'b0;
      next_dir = 1'b0;
      next_role = 1'b0;
      next_ev6 = 1'b0;
      next_af = 1'b0;
      next_stop_detected = 1'b0;
      next_arbitration_lost = 1'b0;
      next_bus_error_flag = 1'b0;
    end
    // summary follows whatever cause is still pending
    next_evf = next_sb || next_ten_bit_header_sent || next_btf || next_address_matched || next_ev6
      || next_af || next_stop_detected || next_arbitration_lost || next_bus_error_flag;
    // a start missed while disabled stays unseen; software checks the lines first
    // busy keeps its value while disabled
    next_busy = busy;
    if (pe)
    begin
      if (stop_det || i_bus_err)
        next_busy = 1'b0;
      else if (start_det)
        next_busy = 1'b1;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      sb <= 1'b0;
      ten_bit_header_sent <= 1'b0;
      transfer_finished <= 1'b0;
      address_matched <= 1'b0;
      dir <= 1'b0;
      role <= 1'b0;
      busy <= 1'b0;
      ev6_hold <= 1'b0;
      af <= 1'b0;
      stop_detected <= 1'b0;
      arbitration_lost <= 1'b0;
      bus_error_flag <= 1'b0;
      event_summary_flag <= 1'b0;
    end
    else
    begin
      sb <= next_sb;
      ten_bit_header_sent <= next_ten_bit_header_sent;
      transfer_finished <= next_btf;
      address_matched <= next_address_matched;
      dir <= next_dir;
      role <= next_role;
      busy <= next_busy;
      ev6_hold <= next_ev6;
      af <= next_af;
      stop_detected <= next_stop_detected;
      arbitration_lost <= next_arbitration_lost;
      bus_error_flag <= next_bus_error_flag;
      event_summary_flag <= next_evf;
    end
  end

  // ****************************************
  // interrupt status, mask and line
  // ****************************************
  logic [7:0] irq_evt;
  assign irq_evt = {i_bus_err, i_arb_lost, stop_det, i_ack_fail,
    i_header_sent, btf_set, i_addr_match, i_start_sent};

  // mask takes a write in the cycle after the strobe
  logic [7:0] next_mask;
  assign next_mask = wr_mask ? i_wdata : irq_mask;

  logic [7:0] next_irq_stat;
  always_comb
  begin
    next_irq_stat = 8'h00;
    if (pe)
      next_irq_stat = (rd_irq ? 8'h00 : irq_stat) | irq_evt;
  end

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      irq_stat <= 8'h00;
      irq_mask <= isfl_pkg::IRQ_MASK_RESET;
    end
    else
    begin
      irq_stat <= next_irq_stat;
      irq_mask <= next_mask;
    end
  end

  // the line follows the enable and mask values of the same cycle as the bits
  // enable bit gates every unmasked sticky event onto one line
  wire next_irq = next_ctrl[isfl_pkg::CTRL_ITE]
    && |(next_irq_stat & next_mask);

  // ****************************************
  // clock stretch and outputs
  // ****************************************
  wire next_hold = next_ctrl[isfl_pkg::CTRL_PE]
    && (next_btf || next_address_matched || next_ten_bit_header_sent || next_sb || next_ev6);

  logic [7:0] s1_val, s2_val;
  assign s1_val = {event_summary_flag, ten_bit_header_sent, dir, busy, transfer_finished, address_matched, role, sb};
  assign s2_val = {3'b000, af, stop_detected, arbitration_lost, bus_error_flag, 1'b0};

  logic [7:0] next_rdata;
  always_comb
  begin
    if (i_rd && i_addr == isfl_pkg::ADDR_CTRL)
      next_rdata = ctrl;
    else if (rd_s1)
      next_rdata = s1_val;
    else if (rd_s2)
      next_rdata = s2_val;
    else if (rd_dr)
      next_rdata = i_rx_byte;
    else if (rd_irq)
      next_rdata = irq_stat;
    else if (i_rd && i_addr == isfl_pkg::ADDR_IRQ_MASK)
      next_rdata = irq_mask;
    else
      next_rdata = 8'h00;
  end

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_rdata <= 8'h00;
      o_tx_byte <= 8'h00;
      o_scl_o <= 1'b0;
      o_scl_oe <= 1'b0;
      o_irq <= 1'b0;
    end
    else
    begin
      o_rdata <= next_rdata;
      if (wr_dr)
        o_tx_byte <= i_wdata;
      o_scl_o <= 1'b0;
      o_scl_oe <= next_hold;
      o_irq <= next_irq;
    end
  end

  // control outputs are the control register bits themselves
  assign o_pe = ctrl[isfl_pkg::CTRL_PE];
  assign o_start_req = ctrl[isfl_pkg::CTRL_START];
  assign o_stop_req = ctrl[isfl_pkg::CTRL_STOP];
  assign o_ack_en = ctrl[isfl_pkg::CTRL_ACK];
  assign o_gc_en = ctrl[isfl_pkg::CTRL_GC];

endmodule : isfl_flags

// file: dv/isfl_flags_checker.sv
// port assertions for the status-flag block
// bound into isfl_flags, sees only that module's ports
`timescale 1ns/1ps

module isfl_flags_checker (
  input wire logic i_mclk, // clock
  input wire logic i_rst, // reset
  input wire logic [2:0] i_addr, // address
  input wire logic i_wr, // write
  input wire logic i_rd, // read
  input wire logic [7:0] o_rdata, // read data
  input wire logic o_scl_o, // clock value
  input wire logic o_scl_oe, // clock pull
  input wire logic i_start_sent, // start
  input wire logic i_header_sent, // header
  input wire logic i_addr_ack, // address ack
  input wire logic i_byte_tx, // byte sent
  input wire logic i_addr_match, // match
  input wire logic o_pe, // enable
  input wire logic o_irq // interrupt
);
  default clocking @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);
  // status_one read with no match arriving, byte sent and master events while running
  sequence s1_rd;
    i_rd && i_addr == isfl_pkg::ADDR_STATUS_ONE && !i_addr_match;
  endsequence
  sequence tx_ev;
    i_byte_tx && o_pe && !i_wr;
  endsequence
  sequence m_ev;
    (i_start_sent || i_header_sent || i_addr_ack) && o_pe && !i_wr;
  endsequence
  // events that must hold the clock low
  btf_hold_a: assert property (tx_ev |-> ##[1:2] o_scl_oe)
    else $error("clock not held after byte");
  match_hold_a: assert property (i_addr_match && o_pe && !i_wr |-> ##[1:2] o_scl_oe)
    else $error("clock not held after match");
  master_hold_a: assert property (m_ev |-> ##[1:2] o_scl_oe)
    else $error("clock not held after master event");
  // pins released and interrupt quiet while disabled
  off_quiet_a: assert property (!o_pe ##1 !o_pe |-> !o_scl_oe && !o_irq)
    else $error("output active while disabled");
  low_only_a: assert property (o_scl_oe |-> o_scl_o == 1'b0)
    else $error("clock driven high");
  // status reads
  off_clear_a: assert property (!o_pe ##1 !o_pe ##0 s1_rd |=> (o_rdata & 8'hEF) == 8'h00)
    else $error("flag set while disabled");
  match_clear_a: assert property (s1_rd ##1 s1_rd |=> !o_rdata[isfl_pkg::S1_ADDRESS_MATCHED])
    else $error("match flag survived a read");
  tx_seen_a: assert property (tx_ev ##1 s1_rd |=> (o_rdata & 8'hA8) == 8'hA8)
    else $error("sent byte not shown");
endmodule : isfl_flags_checker

bind isfl_flags isfl_flags_checker u_isfl_flags_checker (.i_mclk, .i_rst, .i_addr, .i_wr,
  .i_rd, .o_rdata, .o_scl_o, .o_scl_oe, .i_start_sent, .i_header_sent, .i_addr_ack,
  .i_byte_tx, .i_addr_match, .o_pe, .o_irq);

// file: dv/isfl_bus_peer.sv
// model of another master on the open-drain bus lines
// lines have pull-ups, so a released line reads high
`timescale 1ns/1ps

module isfl_bus_peer (
  output logic o_scl_low, // pulls the clock line low
  output logic o_sda_low // pulls the data line low
);
  localparam int HALF = 160; // half of the 320 ns link period
  // idle bus: both lines released
  initial {o_scl_low, o_sda_low} = 2'b00;
  // start, eight bits msb first, released ack slot; clock then parked low
  task automatic frame(input logic [7:0] b);
    o_sda_low = 1'b1;
    #HALF;
    for (int i = 8; i >= 0; i--)
    begin
      o_scl_low = 1'b1;
      #(HALF / 2);
      o_sda_low = (i > 0) && !b[i - 1];
      #(HALF / 2);
      o_scl_low = 1'b0;
      #HALF;
    end
    o_scl_low = 1'b1;
  endtask : frame
  // stop: data released while the clock is high
  task automatic stop();
    o_sda_low = 1'b1;
    #HALF;
    o_scl_low = 1'b0;
    #HALF;
    o_sda_low = 1'b0;
  endtask : stop
endmodule : isfl_bus_peer

// file: dv/isfl_flags_bench.sv
// self-checking bench for the status-flag block, random bytes from a fixed seed
// the checker binds itself; the peer model pulls the two bus lines
`timescale 1ns/1ps

module isfl_flags_bench;
  localparam int k_evt = isfl_pkg::S1_EVF;
  localparam int k_h10 = isfl_pkg::S1_TEN_BIT_HEADER_SENT;
  localparam int k_dir = isfl_pkg::S1_DIR;
  localparam int k_busy = isfl_pkg::S1_BUSY;
  localparam int k_fin = isfl_pkg::S1_BTF;
  localparam int k_match = isfl_pkg::S1_ADDRESS_MATCHED;
  localparam int k_role = isfl_pkg::S1_ROLE;
  localparam int k_start = isfl_pkg::S1_SB;
  logic i_mclk = 1'b0;
  logic i_rst = 1'b1;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [2:0] i_addr = 3'h0;
  logic [7:0] i_wdata = 8'h00;
  logic [7:0] rx_byte = 8'h00;
  logic [8:0] ev = 9'h000;
  logic [7:0] o_rdata, o_tx_byte, d;
  logic o_scl_o, o_scl_oe, o_pe, o_irq, scl_low, sda_low;
  logic o_start_req, o_stop_req, o_ack_en, o_gc_en;
  logic [31:0] rng = 32'h00004BE9;
  int n_mismatch = 0;
  int compares = 0;

  // design and peer share the pulled-up clock and data lines
  isfl_flags u_isfl_flags (.i_mclk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_scl((o_scl_oe ? o_scl_o : 1'b1) & !scl_low), .i_sda(!sda_low), .o_scl_o, .o_scl_oe,
    .i_start_sent(ev[0]), .i_header_sent(ev[1]), .i_addr_ack(ev[2]), .i_byte_tx(ev[3]),
    .i_byte_rx(ev[4]), .i_addr_match(ev[5]), .i_ack_fail(ev[6]), .i_arb_lost(ev[7]),
    .i_bus_err(ev[8]), .i_rx_byte(rx_byte), .o_tx_byte, .o_pe, .o_start_req,
    .o_stop_req, .o_ack_en, .o_gc_en, .o_irq);
  isfl_bus_peer u_isfl_bus_peer (.o_scl_low(scl_low), .o_sda_low(sda_low));

  // 25 MHz clock
  always #20 i_mclk = !i_mclk;

  function automatic logic [7:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng[7:0];
  endfunction : xs
  // expected register byte from a list of set bit positions
  function automatic logic [7:0] m(input int a = -1, input int b = -1, input int c = -1,
    input int e = -1);
    int p[4] = '{a, b, c, e};
    logic [7:0] r = 8'h00;
    foreach (p[k])
      if (p[k] >= 0)
        r[p[k]] = 1'b1;
    return r;
  endfunction : m
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      $display("BAD %s expected %h seen %h", nm, exp, seen);
      n_mismatch++;
    end
  endtask : chk
  // bus cycles: called just after an edge, return just after the next
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_mclk);
    i_wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1;
    chk($sformatf("register %0d", a), o_rdata, e);
  endtask : rd
  task automatic st(input logic [7:0] e);
    rd(isfl_pkg::ADDR_STATUS_ONE, e);
  endtask : st
  task automatic pulse(input int k);
    ev <= 9'h001 << k;
    @(posedge i_mclk);
    ev <= 9'h000;
    #1;
  endtask : pulse
  task automatic idle(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask : idle
  task automatic end_of_test();
    if (n_mismatch == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test

  // hang guard
  initial
  begin
    repeat (20000) @(posedge i_mclk);
    n_mismatch++;
    end_of_test();
  end

  // main sequence
  initial
  begin
    repeat (16) @(posedge i_mclk);
    i_rst <= 1'b0;
    idle(1);
    st(8'h00);
    u_isfl_bus_peer.frame(xs());
    idle(2);
    wr(isfl_pkg::ADDR_CTRL, 8'h3F);
    rd(isfl_pkg::ADDR_CTRL, 8'h22);
    chk("controls", {3'h0, o_pe, o_start_req, o_stop_req, o_ack_en, o_gc_en}, 8'h14);
    wr(isfl_pkg::ADDR_CTRL, 8'h25);
    st(8'h00);
    u_isfl_bus_peer.stop();
    idle(10);
    st(m(k_evt));
    rd(isfl_pkg::ADDR_STATUS_TWO, m(isfl_pkg::S2_STOP_DETECTED));
    st(8'h00);
    rd(isfl_pkg::ADDR_IRQ_STAT, m(isfl_pkg::IRQ_STOP_DETECTED));
    wr(isfl_pkg::ADDR_CTRL, 8'h2D);
    wr(isfl_pkg::ADDR_IRQ_MASK, 8'hFF);
    st(m(k_role));
    chk("controls", {3'h0, o_pe, o_start_req, o_stop_req, o_ack_en, o_gc_en}, 8'h1A);
    pulse(0);
    st(m(k_evt, k_start, k_role));
    chk("controls", {3'h0, o_pe, o_start_req, o_stop_req, o_ack_en, o_gc_en}, 8'h12);
    chk("clock pull", {7'h00, o_scl_oe}, 8'h01);
    chk("irq", {7'h00, o_irq}, 8'h01);
    wr(isfl_pkg::ADDR_DATA, xs());
    st(m(k_role));
    rd(isfl_pkg::ADDR_IRQ_STAT, m(isfl_pkg::IRQ_SB));
    chk("irq", {7'h00, o_irq}, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      pulse(3);
      st(m(k_evt, k_dir, k_fin, k_role));
      chk("clock pull", {7'h00, o_scl_oe}, 8'h01);
      d = xs();
      wr(isfl_pkg::ADDR_DATA, d);
      chk("tx byte", o_tx_byte, d);
      st(m(k_role));
    end
    wr(isfl_pkg::ADDR_IRQ_MASK, 8'h00);
    rd(isfl_pkg::ADDR_IRQ_STAT, m(isfl_pkg::IRQ_BTF));
    d = xs();
    rx_byte <= d;
    pulse(4);
    st(m(k_evt, k_fin, k_role));
    chk("irq", {7'h00, o_irq}, 8'h00);
    rd(isfl_pkg::ADDR_DATA, d);
    st(m(k_role));
    pulse(5);
    st(m(k_evt, k_match, k_role));
    st(m(k_role));
    pulse(1);
    st(m(k_evt, k_h10, k_role));
    rd(isfl_pkg::ADDR_STATUS_TWO, 8'h00);
    wr(isfl_pkg::ADDR_DATA, xs());
    st(m(k_role));
    pulse(6);
    st(m(k_evt, k_role));
    rd(isfl_pkg::ADDR_STATUS_TWO, m(isfl_pkg::S2_AF));
    st(m(k_role));
    pulse(7);
    st(m(k_evt));
    rd(isfl_pkg::ADDR_STATUS_TWO, m(isfl_pkg::S2_ARBITRATION_LOST));
    u_isfl_bus_peer.frame(xs());
    idle(2);
    st(m(k_busy));
    pulse(8);
    st(m(k_evt));
    rd(isfl_pkg::ADDR_STATUS_TWO, m(isfl_pkg::S2_BUS_ERROR_FLAG));
    u_isfl_bus_peer.stop();
    idle(10);
    rd(3'h7, 8'h00);
    pulse(2);
    idle(1);
    chk("clock pull", {7'h00, o_scl_oe}, 8'h01);
    wr(isfl_pkg::ADDR_CTRL, 8'h00);
    idle(2);
    st(8'h00);
    chk("clock pull", {7'h00, o_scl_oe}, 8'h00);
    chk("controls", {3'h0, o_pe, o_start_req, o_stop_req, o_ack_en, o_gc_en}, 8'h00);
    end_of_test();
  end
endmodule : isfl_flags_bench
